// file: hw/ncocfg_pkg.sv
// Constants, types and register map of the oscillator and clock-multiplier configuration bank
// What this block does
// - First-pair frequency word at 0x14/0x15.
// - Second-pair frequency word at 0x16/0x17.
// - Frequency words are signed two's complement.
// - One LSB steps sample_rate over 2^32.
// - Reset bit grounds loop_filter; falling restarts.
// - Alignment enable routes sync; resets to one.
// - Enable runs multiplier, clear bypasses; reset zero.
// - Decode charge_pump_select none/single/dual, 10 unused.
// - Prescaler codes 2..7 direct, 000 gives 8.
// - Loop-filter voltage bits read-only, live.
// - M top clear: divide equals low seven.
// - M top set: divide doubles low seven.
// - M field bits 15:8, resets 0x04.
// - N field encodes code plus one.
package ncocfg_pkg;

  // Register indices; byte address is four times the index
  localparam logic [29:0] IDX_FREQ_AB_LOW  = 30'h0000_0014;
  localparam logic [29:0] IDX_FREQ_AB_HIGH = 30'h0000_0015;
  localparam logic [29:0] IDX_FREQ_CD_LOW  = 30'h0000_0016;
  localparam logic [29:0] IDX_FREQ_CD_HIGH = 30'h0000_0017;
  localparam logic [29:0] IDX_PLL_CTRL     = 30'h0000_0018;
  localparam logic [29:0] IDX_PLL_DIV      = 30'h0000_0019;

  localparam logic [15:0] FREQ_RESET     = 16'h0000;
  localparam logic [15:0] CTRL_RESET     = 16'h2808;
  localparam logic [15:0] CTRL_WR_MASK   = 16'h1CF8;
  localparam logic [15:0] DIV_RESET      = 16'h0440;
  localparam logic [15:0] DIV_WR_MASK    = 16'hFFF0;
  localparam logic [31:0] RDATA_IDLE     = 32'h0000_0000;
  localparam logic [31:0] PHASE_RESET    = 32'h0000_0000;

  // Control field positions
  localparam int CTRL_RST_BIT  = 12;
  localparam int CTRL_NDIV_BIT = 11;
  localparam int CTRL_ENA_BIT  = 10;
  localparam int CP_MSB        = 7;
  localparam int CP_LSB        = 6;
  localparam int PRE_MSB       = 5;
  localparam int PRE_LSB       = 3;
  localparam int LF_MSB        = 2;
  localparam int CTRL_LIVE_LSB = 3;

  // Divider field positions
  localparam int M_TOP_BIT = 15;
  localparam int M_LOW_MSB = 14;
  localparam int M_LOW_LSB = 8;
  localparam int N_MSB     = 7;
  localparam int N_LSB     = 4;

  localparam logic [6:0] M_LOW_MIN      = 7'h04;
  localparam logic [4:0] N_OFFSET       = 5'h01;
  localparam logic [2:0] PRE_CODE_EIGHT = 3'h0;
  localparam logic [2:0] PRE_CODE_ONE   = 3'h1;
  localparam logic [3:0] PRE_RATIO_EIGHT = 4'h8;
  localparam logic [3:0] PRE_RATIO_ONE   = 4'h1;

  localparam logic [1:0] PUMPS_NONE   = 2'h0;
  localparam logic [1:0] PUMPS_SINGLE = 2'h1;
  localparam logic [1:0] PUMPS_DUAL   = 2'h2;

  typedef enum logic [1:0] {
    NCOCFG_CP_NONE   = 2'b00,
    NCOCFG_CP_SINGLE = 2'b01,
    NCOCFG_CP_UNUSED = 2'b10,
    NCOCFG_CP_DUAL   = 2'b11
  } ncocfg_cp_t;

  // Decoded clock-multiplier settings
  typedef struct packed {
    logic       lf_ground;
    logic       restart;
    logic       ndiv_align_ena;
    logic       ndiv_align;
    logic       pll_run;
    logic       pll_bypass;
    ncocfg_cp_t cp_mode;
    logic [1:0] pump_count;
    logic [3:0] prescale_ratio;
    logic [7:0] m_div;
    logic       m_invalid;
    logic [4:0] n_div;
  } ncocfg_pll_cfg_t;

  localparam ncocfg_pll_cfg_t PLL_CFG_RESET = '{
    lf_ground:      1'b0,
    restart:        1'b0,
    ndiv_align_ena: 1'b1,
    ndiv_align:     1'b0,
    pll_run:        1'b0,
    pll_bypass:     1'b1,
    cp_mode:        NCOCFG_CP_NONE,
    pump_count:     PUMPS_NONE,
    prescale_ratio: PRE_RATIO_ONE,
    m_div:          8'h04,
    m_invalid:      1'b0,
    n_div:          5'h05
  };

endpackage

// file: hw/ncocfg_nco_acc.sv
// Numeric oscillator accumulator with a load-on-strobe active frequency word
`timescale 1ns/1ps
module ncocfg_nco_acc
  import ncocfg_pkg::*;
(
  // Clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // Word staging
  input  wire logic               load,
  input  wire logic [31:0]        word_in,
  // Oscillator state
  output logic signed [31:0]      active_word,
  output logic [31:0]             phase
);

  logic signed [31:0] word_reg;
  logic signed [31:0] word_next;
  logic [31:0]        phase_reg;
  logic [31:0]        phase_next;

  always_comb begin
    word_next  = word_reg;
    if (load) begin
      word_next = word_in;
    end
    phase_next = phase_reg + word_reg;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      word_reg  <= PHASE_RESET;
      phase_reg <= PHASE_RESET;
    end else begin
      word_reg  <= word_next;
      phase_reg <= phase_next;
    end
  end

  assign active_word = word_reg;
  assign phase       = phase_reg;

endmodule

// file: hw/ncocfg_regs.sv
// AHB-Lite register bank for oscillator frequency words and clock-multiplier control
`timescale 1ns/1ps
module ncocfg_regs
  import ncocfg_pkg::*;
(
  // AHB-Lite clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // Mixer load strobes
  input  wire logic              mixer_load_first_pair,
  input  wire logic              mixer_load_second_pair,
  // Oscillators
  output logic signed [31:0]     osc_freq_word_first_pair,
  output logic signed [31:0]     osc_freq_word_second_pair,
  output logic [31:0]            osc_phase_first_pair,
  output logic [31:0]            osc_phase_second_pair,
  // Clock multiplier
  input  wire logic              sync_in,
  input  wire logic [2:0]        loop_filter_volt,
  output ncocfg_pll_cfg_t        pll_cfg
);

  // Bus phase tracking
  logic        take;
  logic        wr_pend_reg;
  logic        wr_pend_next;
  logic [29:0] wr_idx_reg;
  logic [29:0] wr_idx_next;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;

  // Register storage
  logic [15:0] f_ab_lo_reg;
  logic [15:0] f_ab_lo_next;
  logic [15:0] f_ab_hi_reg;
  logic [15:0] f_ab_hi_next;
  logic [15:0] f_cd_lo_reg;
  logic [15:0] f_cd_lo_next;
  logic [15:0] f_cd_hi_reg;
  logic [15:0] f_cd_hi_next;
  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_next;
  logic [15:0] div_reg;
  logic [15:0] div_next;

  // Decoded multiplier settings
  ncocfg_pll_cfg_t pll_reg;
  ncocfg_pll_cfg_t pll_next;

  assign take = hsel & hready & htrans[1];

  // Address phase: remember a pending write for the data phase
  always_comb begin
    wr_pend_next = wr_pend_reg;
    wr_idx_next  = wr_idx_reg;
    if (hready) begin
      wr_pend_next = take & hwrite;
      if (take) begin
        wr_idx_next = haddr[31:2];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= IDX_FREQ_AB_LOW;
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_idx_reg  <= wr_idx_next;
    end
  end

  // Data phase writes; unmapped indices are ignored
  always_comb begin
    f_ab_lo_next = f_ab_lo_reg;
    f_ab_hi_next = f_ab_hi_reg;
    f_cd_lo_next = f_cd_lo_reg;
    f_cd_hi_next = f_cd_hi_reg;
    ctrl_next    = ctrl_reg;
    div_next     = div_reg;
    if (wr_pend_reg) begin
      case (wr_idx_reg)
        IDX_FREQ_AB_LOW: begin
          f_ab_lo_next = hwdata[15:0];
        end
        IDX_FREQ_AB_HIGH: begin
          f_ab_hi_next = hwdata[15:0];
        end
        IDX_FREQ_CD_LOW: begin
          f_cd_lo_next = hwdata[15:0];
        end
        IDX_FREQ_CD_HIGH: begin
          f_cd_hi_next = hwdata[15:0];
        end
        IDX_PLL_CTRL: begin
          ctrl_next = (ctrl_reg & ~CTRL_WR_MASK) | (hwdata[15:0] & CTRL_WR_MASK);
        end
        IDX_PLL_DIV: begin
          div_next = (div_reg & ~DIV_WR_MASK) | (hwdata[15:0] & DIV_WR_MASK);
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      f_ab_lo_reg <= FREQ_RESET;
      f_ab_hi_reg <= FREQ_RESET;
      f_cd_lo_reg <= FREQ_RESET;
      f_cd_hi_reg <= FREQ_RESET;
      ctrl_reg    <= CTRL_RESET;
      div_reg     <= DIV_RESET;
    end else begin
      f_ab_lo_reg <= f_ab_lo_next;
      f_ab_hi_reg <= f_ab_hi_next;
      f_cd_lo_reg <= f_cd_lo_next;
      f_cd_hi_reg <= f_cd_hi_next;
      ctrl_reg    <= ctrl_next;
      div_reg     <= div_next;
    end
  end

  // Read data registered at the address phase from next values, so a read
  // right behind a write to the same register returns the new contents
  always_comb begin
    hrdata_next = RDATA_IDLE;
    if (take && !hwrite) begin
      case (haddr[31:2])
        IDX_FREQ_AB_LOW: begin
          hrdata_next = {16'h0000, f_ab_lo_next};
        end
        IDX_FREQ_AB_HIGH: begin
          hrdata_next = {16'h0000, f_ab_hi_next};
        end
        IDX_FREQ_CD_LOW: begin
          hrdata_next = {16'h0000, f_cd_lo_next};
        end
        IDX_FREQ_CD_HIGH: begin
          hrdata_next = {16'h0000, f_cd_hi_next};
        end
        IDX_PLL_CTRL: begin
          hrdata_next = {16'h0000, ctrl_next[15:CTRL_LIVE_LSB], loop_filter_volt};
        end
        IDX_PLL_DIV: begin
          hrdata_next = {16'h0000, div_next};
        end
        default: begin
          hrdata_next = RDATA_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= RDATA_IDLE;
    end else begin
      hrdata_reg <= hrdata_next;
    end
  end

  assign hrdata    = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Multiplier decode
  always_comb begin
    logic [6:0] m_low;
    logic [2:0] pre_code;
    m_low    = div_reg[M_LOW_MSB:M_LOW_LSB];
    pre_code = ctrl_reg[PRE_MSB:PRE_LSB];
    pll_next = pll_reg;
    pll_next.lf_ground      = ctrl_reg[CTRL_RST_BIT];
    pll_next.restart        = pll_reg.lf_ground & ~ctrl_reg[CTRL_RST_BIT];
    pll_next.ndiv_align_ena = ctrl_reg[CTRL_NDIV_BIT];
    pll_next.ndiv_align     = ctrl_reg[CTRL_NDIV_BIT] & sync_in;
    pll_next.pll_run        = ctrl_reg[CTRL_ENA_BIT];
    pll_next.pll_bypass     = ~ctrl_reg[CTRL_ENA_BIT];
    pll_next.cp_mode        = ncocfg_cp_t'(ctrl_reg[CP_MSB:CP_LSB]);
    unique case (ncocfg_cp_t'(ctrl_reg[CP_MSB:CP_LSB]))
      NCOCFG_CP_NONE: begin
        pll_next.pump_count = PUMPS_NONE;
      end
      NCOCFG_CP_SINGLE: begin
        pll_next.pump_count = PUMPS_SINGLE;
      end
      NCOCFG_CP_UNUSED: begin
        pll_next.pump_count = PUMPS_NONE;
      end
      NCOCFG_CP_DUAL: begin
        pll_next.pump_count = PUMPS_DUAL;
      end
    endcase
    if (pre_code == PRE_CODE_EIGHT) begin
      pll_next.prescale_ratio = PRE_RATIO_EIGHT;
    end else if (pre_code == PRE_CODE_ONE) begin
      pll_next.prescale_ratio = PRE_RATIO_ONE;
    end else begin
      pll_next.prescale_ratio = {1'b0, pre_code};
    end
    if (div_reg[M_TOP_BIT]) begin
      pll_next.m_div = {m_low, 1'b0};
    end else begin
      pll_next.m_div = {1'b0, m_low};
    end
    pll_next.m_invalid = (m_low < M_LOW_MIN);
    pll_next.n_div     = {1'b0, div_reg[N_MSB:N_LSB]} + N_OFFSET;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pll_reg <= PLL_CFG_RESET;
    end else begin
      pll_reg <= pll_next;
    end
  end

  assign pll_cfg = pll_reg;

  // Oscillators take the staged words only on their load strobes
  ncocfg_nco_acc u_acc_first (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .load        (mixer_load_first_pair),
    .word_in     ({f_ab_hi_reg, f_ab_lo_reg}),
    .active_word (osc_freq_word_first_pair),
    .phase       (osc_phase_first_pair)
  );

  ncocfg_nco_acc u_acc_second (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .load        (mixer_load_second_pair),
    .word_in     ({f_cd_hi_reg, f_cd_lo_reg}),
    .active_word (osc_freq_word_second_pair),
    .phase       (osc_phase_second_pair)
  );

endmodule

// file: verification/ncocfg_properties.sv
// Port-level checks for the oscillator and clock-multiplier register bank
`timescale 1ns/1ps
module ncocfg_properties
  import ncocfg_pkg::*;
(
  // Clock and reset
  input wire logic               hclk,
  input wire logic               hresetn,
  // Bus
  input wire logic               hsel,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic               hready,
  input wire logic               hreadyout,
  input wire logic               hresp,
  input wire logic [31:0]        hrdata,
  // Oscillators
  input wire logic               mixer_load_first_pair,
  input wire logic               mixer_load_second_pair,
  input wire logic signed [31:0] osc_freq_word_first_pair,
  input wire logic signed [31:0] osc_freq_word_second_pair,
  input wire logic [31:0]        osc_phase_first_pair,
  input wire logic [31:0]        osc_phase_second_pair,
  // Clock multiplier
  input wire ncocfg_pll_cfg_t    pll_cfg
);
  logic rd_take;
  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence lf_release;
    $fell(pll_cfg.lf_ground);
  endsequence
  sequence one_pulse;
    pll_cfg.restart ##1 !pll_cfg.restart;
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_rdata_idle: assert property (!rd_take |=> hrdata == RDATA_IDLE)
    else $error("read data outside a read");
  a_rdata_upper: assert property (rd_take |=> hrdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_acc_first: assert property (osc_phase_first_pair == 32'($past(osc_phase_first_pair) + $past(osc_freq_word_first_pair)))
    else $error("first accumulator step wrong");
  a_acc_second: assert property (osc_phase_second_pair == 32'($past(osc_phase_second_pair) + $past(osc_freq_word_second_pair)))
    else $error("second accumulator step wrong");
  a_word_hold: assert property (!mixer_load_first_pair |=> $stable(osc_freq_word_first_pair))
    else $error("active word changed without load");
  a_word_hold_second: assert property (!mixer_load_second_pair |=> $stable(osc_freq_word_second_pair))
    else $error("second active word changed without load");
  a_bypass_run: assert property (pll_cfg.pll_bypass != pll_cfg.pll_run)
    else $error("bypass and run disagree");
  a_pump_decode: assert property (pll_cfg.pump_count == ((pll_cfg.cp_mode == NCOCFG_CP_DUAL) ? 2'h2 :
    (pll_cfg.cp_mode == NCOCFG_CP_SINGLE) ? 2'h1 : 2'h0)) else $error("pump count decode wrong");
  a_restart_fall: assert property (lf_release |-> one_pulse)
    else $error("no restart pulse on release");
endmodule
bind ncocfg_regs ncocfg_properties u_ncocfg_properties (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .mixer_load_first_pair(mixer_load_first_pair), .mixer_load_second_pair(mixer_load_second_pair),
  .osc_freq_word_first_pair(osc_freq_word_first_pair),
  .osc_freq_word_second_pair(osc_freq_word_second_pair), .osc_phase_first_pair(osc_phase_first_pair),
  .osc_phase_second_pair(osc_phase_second_pair), .pll_cfg(pll_cfg));

// file: verification/ncocfg_tb.sv
// Self-checking bench for the oscillator and clock-multiplier register bank
`timescale 1ns/1ps
module testbench
  import ncocfg_pkg::*;
;
  logic                   hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, ld_a, ld_b, sync_in;
  logic [1:0]             htrans;
  logic [2:0]             hsize, volt;
  logic [31:0]            haddr, hwdata, hrdata, ph_a, ph_b, rd, p;
  logic signed [31:0]     fw_a, fw_b;
  ncocfg_pll_cfg_t        cfg;
  int                     miscompares, checks_done;
  assign hready = hreadyout;
  ncocfg_regs u_ncocfg_regs (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .mixer_load_first_pair(ld_a), .mixer_load_second_pair(ld_b),
    .osc_freq_word_first_pair(fw_a), .osc_freq_word_second_pair(fw_b), .osc_phase_first_pair(ph_a),
    .osc_phase_second_pair(ph_b), .sync_in(sync_in), .loop_filter_volt(volt), .pll_cfg(cfg));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      miscompares++;
      end_sim();
    end
  endtask
  // One single word transfer; read data lands in rd
  task automatic xfer(input logic w, input logic [29:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic rchk(input logic [29:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0000_0000);
    chk(rd, exp);
  endtask
  // Ends on a rising edge so the next stimulus launches there; decode is a cycle behind the register
  task automatic settle();
    repeat (2) @(posedge hclk);
  endtask
  task automatic t_reset();
    for (int i = 0; i < 4; i++) rchk(IDX_FREQ_AB_LOW + 30'(i), 32'h0000_0000);
    rchk(IDX_PLL_CTRL, 32'h0000_280D);
    rchk(IDX_PLL_DIV, 32'h0000_0440);
    chk(32'(cfg), 32'(PLL_CFG_RESET));
  endtask
  task automatic t_freq();
    xfer(1'b1, IDX_FREQ_AB_LOW, 32'h0000_5678);
    xfer(1'b1, IDX_FREQ_AB_HIGH, 32'h0000_F234);
    xfer(1'b1, IDX_FREQ_CD_LOW, 32'h0000_0001);
    xfer(1'b1, IDX_FREQ_CD_HIGH, 32'h0000_0000);
    rchk(IDX_FREQ_AB_HIGH, 32'h0000_F234);
    rchk(IDX_FREQ_CD_LOW, 32'h0000_0001);
    chk(fw_a, 32'h0000_0000);
    chk(fw_b, 32'h0000_0000);
    ld_a <= 1'b1;
    ld_b <= 1'b1;
    @(posedge hclk);
    ld_a <= 1'b0;
    ld_b <= 1'b0;
    @(posedge hclk);
    chk(fw_a, 32'hF234_5678);
    chk(fw_b, 32'h0000_0001);
    p = ph_a;
    @(posedge hclk);
    chk(ph_a - p, 32'hF234_5678);
  endtask
  task automatic t_ctrl();
    sync_in <= 1'b1;
    xfer(1'b1, IDX_PLL_CTRL, 32'h0000_FFFF);
    settle();
    chk({cfg.lf_ground, cfg.pll_run, cfg.pll_bypass, cfg.ndiv_align}, 4'b1101);
    rchk(IDX_PLL_CTRL, 32'h0000_3CFD);
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, IDX_PLL_CTRL, {24'h0000_00, 2'(i), 3'(i), 3'h0});
      settle();
      chk(cfg.pump_count, (i % 4 == 3) ? 2 : (i % 4 == 1) ? 1 : 0);
      chk(cfg.prescale_ratio, (i == 0) ? 8 : i);
    end
    volt <= 3'h2;
    rchk(IDX_PLL_CTRL, 32'h0000_20FA);
  endtask
  task automatic t_div();
    logic [15:0] wv[5] = '{16'h8FFF, 16'h7F00, 16'h0300, 16'h8400, 16'h8300};
    logic [13:0] ev[5] = '{{1'b0, 8'h1E, 5'h10}, {1'b0, 8'h7F, 5'h01}, {1'b1, 8'h03, 5'h01},
                           {1'b0, 8'h08, 5'h01}, {1'b1, 8'h06, 5'h01}};
    for (int i = 0; i < 5; i++) begin
      xfer(1'b1, IDX_PLL_DIV, {16'h0000, wv[i]});
      settle();
      chk({cfg.m_invalid, cfg.m_div, cfg.n_div}, ev[i]);
      rchk(IDX_PLL_DIV, {16'h0000, wv[i][15:4], 4'h0});
    end
    xfer(1'b1, 30'h0000_001A, 32'h0000_FFFF);
    rchk(30'h0000_001A, 32'h0000_0000);
  endtask
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  initial begin
    hresetn <= 1'b0;
    hsel <= 1'b0;
    haddr <= 32'h0000_0000;
    htrans <= 2'b00;
    hwrite <= 1'b0;
    hsize <= 3'h2;
    hwdata <= 32'h0000_0000;
    ld_a <= 1'b0;
    ld_b <= 1'b0;
    sync_in <= 1'b0;
    volt <= 3'h5;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_freq();
    t_ctrl();
    t_div();
    end_sim();
  end
endmodule
